// ===== hdl/smbus_div_cfg.svh
// Notes on behaviour
// RL1: Answer only address 1110001; bit eight is direction.
// RL2: Decode only the top three command bits.
// RL3: 000 On, 011 Off, 001 Setup, 010 Read-Back.
// RL4: Setup takes five upper bits as divider code.
// RL5: Start/stop are data edges while clock high.
// RL6: Write: address, command, low, high; sample on rise.
// RL7: Wrong address: idle until next start.
// RL8: Address match: pull data low one clock; read address only after Read-Back.
// RL9: Acknowledge the command byte after eight bits.
// RL10: Acknowledge data always; store only on Setup.
// RL11: Low byte to register 0, high to 1.
// RL12: After last write acknowledge, return to idle.
// RL13: Read-Back: repeated start, read address, send register 0.
// RL14: Host acknowledge, then send register 1.
// RL15: Host does not acknowledge; device goes idle.
// RL16: Read byte: code, then off flag bit 2.
// RL17: Two lowest read bits are always zero.
// RL18: On/Off act only with the enable pin.
// RL19: Reset sets off flag, holds run output low.
// RL20: Two successive On commands clear the off flag.
// RL21: Two successive Off commands set the off flag.
// RL22: Flag low and enable high: release run output.
// RL23: Invalid command changes no register nor flag.
`ifndef SMBUS_DIV_CFG_SVH
`define SMBUS_DIV_CFG_SVH

`define SLAVE_ADDR 7'h71
`define CMD_ON 3'h0
`define CMD_OFF 3'h3
`define CMD_SETUP 3'h1
`define CMD_READBACK 3'h2
`define CODE_RESET 5'h00
`define OFF_FLAG_RESET 1'h1

`define REG_CTRL 4'h0
`define REG_WDATA 4'h4
`define REG_STATUS 4'h8
`define REG_RDATA 4'hC
`define STATUS_BUSY 0
`define STATUS_NACK 1

`define CLK_PERIOD_NS 8
`define T_QUARTER_NS 2500
`define QUARTER_CYC ((`T_QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== hdl/smbus_div_pkg.sv
package smbus_div_pkg;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RX,
    S_ACK,
    S_TX,
    S_TXACK
  } dev_state_e;

  typedef enum logic [2:0] {
    E_START,
    E_WR,
    E_RD_ACK,
    E_RD_NACK,
    E_STOP
  } host_elem_e;

endpackage

// ===== hdl/smbus_div_if.sv
`timescale 1ns/1ps
interface smbus_div_if;
  logic scl;
  logic sda;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // Open-drain wires with pull-up
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface

// ===== hdl/divider_code_slave.sv
`timescale 1ns/1ps
`include "smbus_div_cfg.svh"
module divider_code_slave
  import smbus_div_pkg::*;
(
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  smbus_div_if.dev bus, // Two-wire bus, device end
  input wire logic regulator_enable_pin, // External enable, asynchronous
  output logic run_low_oe, // Pulls converter run output low
  output logic converter_off_flag, // Converter held off
  output logic [4:0] divider_code_low, // Register 0 code
  output logic [4:0] divider_code_high, // Register 1 code
  output logic cmd_done // Pulse: valid write word finished
);

  logic scl_s1;
  logic scl_s2;
  logic scl_s3;
  logic sda_s1;
  logic sda_s2;
  logic sda_s3;
  logic en_s1;
  logic en_s2;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  dev_state_e st;
  logic [3:0] cnt;
  logic [1:0] idx;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [2:0] cmd;
  logic rw;
  logic rd_hi;
  logic host_ack;
  logic sda_low;
  logic pend_on;
  logic pend_off;
  logic byte_end;
  logic word_end;
  logic [7:0] rd_byte0;
  logic [7:0] rd_byte1;

  assign bus.dev_sda_o = 1'h0;
  assign bus.dev_sda_oe = sda_low;

  // Bus and enable pins cross into sys_clk
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'h1;
      scl_s2 <= 1'h1;
      scl_s3 <= 1'h1;
      sda_s1 <= 1'h1;
      sda_s2 <= 1'h1;
      sda_s3 <= 1'h1;
      en_s1 <= 1'h0;
      en_s2 <= 1'h0;
    end else begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      en_s1 <= regulator_enable_pin;
      en_s2 <= en_s1;
    end
  end

  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_cond = scl_s2 & scl_s3 & sda_s3 & ~sda_s2; // RL5
  assign stop_cond = scl_s2 & scl_s3 & ~sda_s3 & sda_s2; // RL5

  // Read bytes: code, off flag, two zero bits
  assign rd_byte0 = {divider_code_low, converter_off_flag, 2'h0}; // RL16 RL17
  assign rd_byte1 = {divider_code_high, converter_off_flag, 2'h0}; // RL16 RL17

  // Last falling edge of a received byte
  assign byte_end = (st == S_RX) && scl_fall && (cnt == 4'h8);
  assign word_end = byte_end && !rw && (idx == 2'h3);

  // Bit-level protocol engine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= S_IDLE;
      cnt <= 4'h0;
      idx <= 2'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      cmd <= 3'h7;
      rw <= 1'h0;
      rd_hi <= 1'h0;
      host_ack <= 1'h0;
      sda_low <= 1'h0;
    end else if (start_cond) begin
      // Start and repeated start both restart at the address byte
      st <= S_RX;
      cnt <= 4'h0;
      idx <= 2'h0;
      sda_low <= 1'h0;
    end else if (stop_cond) begin
      st <= S_IDLE;
      sda_low <= 1'h0;
    end else begin
      unique case (st)
        S_IDLE: begin
          sda_low <= 1'h0;
        end
        S_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s2}; // RL6
            cnt <= cnt + 4'h1;
          end else if (byte_end) begin
            cnt <= 4'h0;
            if (idx == 2'h0) begin
              if (shreg[7:1] != `SLAVE_ADDR) begin
                st <= S_IDLE; // RL7
              end else if (shreg[0] && cmd != `CMD_READBACK) begin
                st <= S_IDLE;
              end else begin
                rw <= shreg[0]; // RL1
                st <= S_ACK;
                sda_low <= 1'h1; // RL8 RL13
              end
            end else begin
              if (idx == 2'h1) begin
                cmd <= shreg[7:5]; // RL2
              end
              st <= S_ACK;
              sda_low <= 1'h1; // RL9 RL10
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              st <= S_TX;
              txreg <= rd_byte0; // RL13
              sda_low <= ~rd_byte0[7];
              rd_hi <= 1'h0;
              cnt <= 4'h0;
            end else if (idx == 2'h3) begin
              st <= S_IDLE; // RL12
              sda_low <= 1'h0;
            end else begin
              st <= S_RX;
              idx <= idx + 2'h1;
              sda_low <= 1'h0;
            end
          end
        end
        S_TX: begin
          if (scl_rise) begin
            cnt <= cnt + 4'h1;
          end else if (scl_fall) begin
            if (cnt == 4'h8) begin
              sda_low <= 1'h0;
              st <= S_TXACK;
            end else begin
              sda_low <= ~txreg[6];
              txreg <= {txreg[6:0], 1'h0};
            end
          end
        end
        S_TXACK: begin
          if (scl_rise) begin
            host_ack <= ~sda_s2;
          end else if (scl_fall) begin
            if (host_ack && !rd_hi) begin
              st <= S_TX; // RL14
              txreg <= rd_byte1;
              sda_low <= ~rd_byte1[7];
              rd_hi <= 1'h1;
              cnt <= 4'h0;
            end else begin
              st <= S_IDLE; // RL15
              sda_low <= 1'h0;
            end
          end
        end
      endcase
    end
  end

  // Divider code registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divider_code_low <= `CODE_RESET;
      divider_code_high <= `CODE_RESET;
    end else if (byte_end && !rw && cmd == `CMD_SETUP) begin // RL10 RL23
      if (idx == 2'h2) begin
        divider_code_low <= shreg[7:3]; // RL4 RL11
      end
      if (idx == 2'h3) begin
        divider_code_high <= shreg[7:3]; // RL4 RL11
      end
    end
  end

  // On/Off sequencing, applied when the write word completes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_off_flag <= `OFF_FLAG_RESET; // RL19
      pend_on <= 1'h0;
      pend_off <= 1'h0;
      cmd_done <= 1'h0;
    end else begin
      cmd_done <= 1'h0;
      if (word_end) begin
        unique case (cmd) // RL3
          `CMD_ON: begin
            pend_off <= 1'h0;
            pend_on <= ~pend_on;
            if (pend_on) begin
              converter_off_flag <= 1'h0; // RL20
            end
            cmd_done <= 1'h1;
          end
          `CMD_OFF: begin
            pend_on <= 1'h0;
            pend_off <= ~pend_off;
            if (pend_off) begin
              converter_off_flag <= 1'h1; // RL21
            end
            cmd_done <= 1'h1;
          end
          `CMD_SETUP: begin
            pend_on <= 1'h0;
            pend_off <= 1'h0;
            cmd_done <= 1'h1;
          end
          default: begin
            pend_on <= pend_on; // RL23
          end
        endcase
      end
    end
  end

  // Run output released only when bus and pin both allow it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_low_oe <= 1'h1; // RL19
    end else begin
      run_low_oe <= converter_off_flag | ~en_s2; // RL18 RL22
    end
  end

endmodule // divider_code_slave

// ===== hdl/divider_code_host.sv
`timescale 1ns/1ps
`include "smbus_div_cfg.svh"
module divider_code_host
  import smbus_div_pkg::*;
#(
  parameter int unsigned QUARTER_CYC = `QUARTER_CYC
)
(
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic wb_cyc, // Wishbone cycle
  input wire logic wb_stb, // Wishbone strobe
  input wire logic wb_we, // Wishbone write enable
  input wire logic [3:0] wb_adr, // Wishbone byte address
  input wire logic [31:0] wb_dat_w, // Wishbone write data
  input wire logic [3:0] wb_sel, // Wishbone byte lanes
  output logic [31:0] wb_dat_r, // Wishbone read data
  output logic wb_ack, // Wishbone acknowledge
  smbus_div_if.host bus // Two-wire bus, host end
);

  logic sda_s1;
  logic sda_s2;
  logic busy;
  logic nack;
  logic is_read;
  logic [7:0] cmd_byte;
  logic [7:0] wlo;
  logic [7:0] whi;
  logic [7:0] rlo;
  logic [7:0] rhi;
  logic [7:0] rx;
  logic got_nack;
  logic [3:0] ei;
  logic [3:0] bitn;
  logic [1:0] qc;
  logic [15:0] tcnt;
  logic tick;
  logic scl_low;
  logic sda_low;
  logic next_scl_low;
  logic next_sda_low;
  host_elem_e cur_kind;
  logic [7:0] cur_byte;
  logic wb_req;

  assign bus.host_scl_o = 1'h0;
  assign bus.host_sda_o = 1'h0;
  assign bus.host_scl_oe = scl_low;
  assign bus.host_sda_oe = sda_low;
  assign tick = busy && (tcnt == 16'(QUARTER_CYC - 1));
  assign wb_req = wb_cyc && wb_stb && !wb_ack;

  // Transfer script
  always_comb begin
    cur_kind = E_STOP;
    cur_byte = 8'h00;
    unique case (ei)
      4'h0: cur_kind = E_START; // RL5
      4'h1: begin
        cur_kind = E_WR;
        cur_byte = {`SLAVE_ADDR, 1'h0}; // RL1 RL6
      end
      4'h2: begin
        cur_kind = E_WR;
        cur_byte = cmd_byte;
      end
      4'h3: begin
        cur_kind = is_read ? E_START : E_WR; // RL13
        cur_byte = wlo;
      end
      4'h4: begin
        cur_kind = E_WR;
        cur_byte = is_read ? {`SLAVE_ADDR, 1'h1} : whi;
      end
      4'h5: cur_kind = is_read ? E_RD_ACK : E_STOP; // RL14
      4'h6: cur_kind = E_RD_NACK; // RL15
      default: cur_kind = E_STOP;
    endcase
  end

  // Line levels per quarter of a bit
  always_comb begin
    next_scl_low = 1'h0;
    next_sda_low = 1'h0;
    if (busy) begin
      next_scl_low = !(qc == 2'h1 || qc == 2'h2);
      unique case (cur_kind)
        E_START: next_sda_low = (qc >= 2'h2);
        E_STOP: begin
          next_sda_low = (qc < 2'h2);
          if (qc == 2'h3) begin
            next_scl_low = 1'h0;
          end
        end
        E_WR: next_sda_low = (bitn == 4'h8) ? 1'h0 : ~cur_byte[3'(4'h7 - bitn)];
        E_RD_ACK: next_sda_low = (bitn == 4'h8);
        E_RD_NACK: next_sda_low = 1'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_s1 <= 1'h1;
      sda_s2 <= 1'h1;
      scl_low <= 1'h0;
      sda_low <= 1'h0;
    end else begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      scl_low <= next_scl_low;
      sda_low <= next_sda_low;
    end
  end

  // Sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'h0;
      nack <= 1'h0;
      ei <= 4'h0;
      bitn <= 4'h0;
      qc <= 2'h0;
      tcnt <= 16'h0000;
      rx <= 8'h00;
      got_nack <= 1'h0;
      rlo <= 8'h00;
      rhi <= 8'h00;
    end else if (!busy) begin
      if (wb_req && wb_we && wb_sel[0] && wb_adr == `REG_CTRL) begin
        busy <= 1'h1;
        nack <= 1'h0;
        ei <= 4'h0;
        bitn <= 4'h0;
        qc <= 2'h0;
        tcnt <= 16'h0000;
      end
    end else begin
      tcnt <= tick ? 16'h0000 : tcnt + 16'h0001;
      if (tick) begin
        qc <= qc + 2'h1;
        if (qc == 2'h2) begin
          // Keep the acknowledge slot out of the received byte
          if (bitn != 4'h8) begin
            rx <= {rx[6:0], sda_s2};
          end
          got_nack <= sda_s2;
        end
        if (qc == 2'h3) begin
          if (cur_kind == E_START || cur_kind == E_STOP) begin
            ei <= ei + 4'h1;
            if (cur_kind == E_STOP) begin
              busy <= 1'h0;
            end
          end else if (bitn != 4'h8) begin
            bitn <= bitn + 4'h1;
          end else begin
            bitn <= 4'h0;
            ei <= ei + 4'h1;
            if (cur_kind == E_WR && got_nack) begin
              nack <= 1'h1;
              ei <= is_read ? 4'h7 : 4'h5;
            end
            if (cur_kind == E_RD_ACK) begin
              rlo <= rx;
            end
            if (cur_kind == E_RD_NACK) begin
              rhi <= rx;
            end
          end
        end
      end
    end
  end

  // Software-written orders
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_byte <= 8'h00;
      is_read <= 1'h0;
      wlo <= 8'h00;
      whi <= 8'h00;
    end else if (wb_req && wb_we) begin
      if (wb_adr == `REG_CTRL && wb_sel[0] && !busy) begin
        cmd_byte <= wb_dat_w[7:0];
        is_read <= (wb_dat_w[7:5] == `CMD_READBACK);
      end
      if (wb_adr == `REG_WDATA && wb_sel[0]) begin
        wlo <= wb_dat_w[7:0];
      end
      if (wb_adr == `REG_WDATA && wb_sel[1]) begin
        whi <= wb_dat_w[15:8];
      end
    end
  end

  // Wishbone answer one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack <= 1'h0;
      wb_dat_r <= 32'h00000000;
    end else begin
      wb_ack <= wb_req;
      if (wb_req && !wb_we) begin
        unique case (wb_adr)
          `REG_CTRL: wb_dat_r <= {24'h000000, cmd_byte};
          `REG_WDATA: wb_dat_r <= {16'h0000, whi, wlo};
          `REG_STATUS: wb_dat_r <= {30'h00000000, nack, busy};
          `REG_RDATA: wb_dat_r <= {16'h0000, rhi, rlo};
          default: wb_dat_r <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // divider_code_host

// ===== test/smbus_div_monitor.sv
`timescale 1ns/1ps
module smbus_div_monitor (
  input wire logic sys_clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic scl, // Resolved clock line
  input wire logic sda, // Resolved data line
  input wire logic dev_sda_oe, // Device pulls data low
  input wire logic regulator_enable_pin, // External enable
  input wire logic run_low_oe, // Run output pulled low
  input wire logic converter_off_flag, // Converter held off
  input wire logic cmd_done // Write word finished
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // One clock period seen from the device side: a rise, then a fall
  sequence bit_period;
    ##[1:40] $rose(scl) ##[1:40] $fell(scl);
  endsequence
  sequence bus_stop;
    scl && $rose(sda);
  endsequence
  a_reset_state: assert property ($rose(rst_n) |-> converter_off_flag && run_low_oe)
    else $error("off flag or run hold missing after reset");
  a_flag_holds_run: assert property (converter_off_flag |=> run_low_oe)
    else $error("run output released while off flag set");
  a_enable_low_run: assert property (!regulator_enable_pin [*5] |-> run_low_oe)
    else $error("run output released while enable low");
  a_run_released: assert property ((regulator_enable_pin && !converter_off_flag) [*5]
    |-> !run_low_oe)
    else $error("run output still held low");
  a_dev_moves_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changed data while clock high");
  a_ack_holds_bit: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout bit_period)
    else $error("device drive shorter than one clock period");
  a_start_dev_quiet: assert property (scl && $fell(sda) |-> !dev_sda_oe)
    else $error("device pulled data low while clock high");
  a_stop_idle: assert property (bus_stop |=> !dev_sda_oe [*8])
    else $error("device drives data after stop");
  a_done_pulse: assert property (cmd_done |=> !cmd_done)
    else $error("done pulse longer than one cycle");
endmodule // smbus_div_monitor

// ===== test/tb_top.sv
`timescale 1ns/1ps
`include "smbus_div_cfg.svh"
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regulator_enable_pin = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [3:0] wb_adr = 4'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic run_low_oe;
  logic converter_off_flag;
  logic cmd_done;
  logic [4:0] divider_code_low;
  logic [4:0] divider_code_high;
  logic [31:0] q;
  logic [4:0] m_lo = 5'h00;
  logic [4:0] m_hi = 5'h00;
  logic m_off = 1'b1;
  int pend_on = 0;
  int pend_off = 0;
  int bad_count = 0;
  int compares = 0;
  int seed = 65;
  int done_count = 0;

  smbus_div_if bus_if();
  divider_code_slave i_divider_code_slave (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus_if.dev),
    .regulator_enable_pin(regulator_enable_pin), .run_low_oe(run_low_oe),
    .converter_off_flag(converter_off_flag), .divider_code_low(divider_code_low),
    .divider_code_high(divider_code_high), .cmd_done(cmd_done));
  divider_code_host #(.QUARTER_CYC(4)) i_divider_code_host (.sys_clk(sys_clk), .rst_n(rst_n),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_w(wb_dat_w),
    .wb_sel(wb_sel), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .bus(bus_if.host));
  smbus_div_monitor i_smbus_div_monitor (.sys_clk(sys_clk), .rst_n(rst_n), .scl(bus_if.scl),
    .sda(bus_if.sda), .dev_sda_oe(bus_if.dev_sda_oe),
    .regulator_enable_pin(regulator_enable_pin), .run_low_oe(run_low_oe),
    .converter_off_flag(converter_off_flag), .cmd_done(cmd_done));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // Counts finished write words reported by the device
  always @(posedge sys_clk) begin
    if (cmd_done === 1'b1) begin
      done_count++;
    end
  end

  task end_sim;
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  function automatic logic [7:0] exp_byte(input logic [4:0] code);
    return {code, m_off, 2'b00};
  endfunction

  function automatic logic [7:0] exp_done(input logic [2:0] top);
    return (top == `CMD_ON || top == `CMD_OFF || top == `CMD_SETUP) ? 8'h01 : 8'h00;
  endfunction

  task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_sel <= 4'hF;
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  // One full bus transfer, then the model follows the command
  task run(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
    int d0;
    d0 = done_count;
    wb(1'b1, `REG_WDATA, {16'h0000, hi, lo});
    wb(1'b1, `REG_CTRL, {24'h000000, c});
    do wb(1'b0, `REG_STATUS, 32'h0); while (q[`STATUS_BUSY] !== 1'b0);
    chk({7'h00, q[`STATUS_NACK]}, 8'h00, "bytes not acknowledged");
    chk(8'(done_count - d0), exp_done(c[7:5]), "done pulses");
    case (c[7:5])
      `CMD_ON: begin
        pend_off = 0;
        pend_on++;
        if (pend_on == 2) begin
          m_off = 1'b0;
          pend_on = 0;
        end
      end
      `CMD_OFF: begin
        pend_on = 0;
        pend_off++;
        if (pend_off == 2) begin
          m_off = 1'b1;
          pend_off = 0;
        end
      end
      `CMD_SETUP: begin
        m_lo = lo[7:3];
        m_hi = hi[7:3];
        pend_on = 0;
        pend_off = 0;
      end
      `CMD_READBACK: begin
        wb(1'b0, `REG_RDATA, 32'h0);
        chk(q[7:0], exp_byte(m_lo), "first read byte");
        chk(q[15:8], exp_byte(m_hi), "second read byte");
      end
      default: ;
    endcase
    chk({3'h0, divider_code_low}, {3'h0, m_lo}, "low code");
    chk({3'h0, divider_code_high}, {3'h0, m_hi}, "high code");
    chk({7'h00, converter_off_flag}, {7'h00, m_off}, "off flag");
  endtask

  task run_pin(input logic v, input logic exp);
    regulator_enable_pin <= v;
    repeat (8) @(posedge sys_clk);
    chk({7'h00, run_low_oe}, {7'h00, exp}, "run output");
  endtask

  initial begin
    logic [7:0] lo;
    logic [7:0] hi;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk({7'h00, converter_off_flag}, 8'h01, "reset flag");
    chk({7'h00, run_low_oe}, 8'h01, "reset run");
    wb(1'b0, 4'h2, 32'h0);
    chk(q[7:0], 8'h00, "unmapped read");
    run(8'h5A, 8'h00, 8'h00);
    for (int i = 0; i < 6; i++) begin
      lo = (i == 0) ? 8'hFF : 8'($random(seed));
      hi = (i == 0) ? 8'h07 : 8'($random(seed));
      run({3'b001, 5'($random(seed))}, lo, hi);
      run({3'b010, 5'($random(seed))}, 8'($random(seed)), 8'h00);
    end
    run(8'h00, 8'($random(seed)), 8'($random(seed)));
    run(8'h3F, 8'hA8, 8'h50);
    run(8'h1F, 8'($random(seed)), 8'($random(seed)));
    run(8'h4C, 8'h00, 8'h00);
    run(8'h00, 8'($random(seed)), 8'($random(seed)));
    run(8'h40, 8'h00, 8'h00);
    run_pin(1'b1, 1'b0);
    for (int c = 4; c < 8; c++)
      run({3'(c), 5'($random(seed))}, 8'($random(seed)), 8'($random(seed)));
    run_pin(1'b0, 1'b1);
    run_pin(1'b1, 1'b0);
    run(8'h60, 8'($random(seed)), 8'($random(seed)));
    run(8'h7F, 8'($random(seed)), 8'($random(seed)));
    run_pin(1'b1, 1'b1);
    run(8'h41, 8'h00, 8'h00);
    end_sim();
  end

  initial begin
    #(8 * 60000);
    bad_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    end_sim();
  end
endmodule // tb_top
